/* design/output_channel_divider_config.sv */
// register block and AXI4-Lite slave for two clock dividers and two pairs
// assumes aclk at 20 MHz, source clock levels sampled on aclk
//
// Overview of operation
// R1 - start-level bit clear starts divider 0 low, set starts it high
// R2 - divider 0 has a four-bit phase offset in bits 3..0, reset zero
// R3 - routing bit 1 clear: both pair 0 outputs come from divider 0
// R4 - direct bit set with source 10: oscillator drives pair 0 undivided
// R5 - direct bit set with source 00: external clock drives pair 0
// R6 - source 01: direct bit changes nothing
// R7 - routing bit 0 clear enables duty correction on divider 0
// R8 - divider 1 low time is bits 7..4 plus one input cycles
// R9 - divider 1 high time is bits 3..0 plus one input cycles
// R10 - divider 1 bypass bit passes its input straight to its output
// R11 - divider 1 bypass resets clear, so the divider is in use
// R12 - bit 6 clear obeys chip sync, set ignores it
// R13 - bit 5 forces divider 1 high, needs ignore-sync set too
// R14 - start-level bit sits at bit 4
// R15 - period is low count plus one plus high count plus one
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
`include "ocd_params.svh"
module output_channel_divider_config (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic osc_clk_level,
  input wire logic ext_clk_level,
  input wire logic sync_n,
  output logic pair0_output_a,
  output logic pair0_output_b,
  output logic pair1_output_a,
  output logic pair1_output_b
);
  ocd_pkg::top_state_t s_r;
  ocd_pkg::top_state_t s_nxt;
  logic [31:0] rd_val;
  logic rd_hit;
  logic wr_hit;
  logic div_src;
  logic sync_active;

  div_cfg_if d0 ();
  div_cfg_if d1 ();

  // ****************************************************************
  // divider settings
  // ****************************************************************
  assign div_src = s_r.srcsel[1] ? osc_clk_level : ext_clk_level;
  assign sync_active = ~sync_n;

  assign d0.low_cnt = s_r.cnt0[`LOW_MSB:`LOW_LSB];
  assign d0.high_cnt = s_r.cnt0[`HIGH_MSB:`HIGH_LSB];
  assign d0.phase = s_r.start0[`PH_MSB:`PH_LSB]; // see R2
  assign d0.start_high = s_r.start0[`BIT_START]; // see R1, R14
  assign d0.dcc_en = ~s_r.route0[`BIT_DCC_OFF]; // see R7
  assign d0.bypass = 1'b0;
  assign d0.hold = sync_active;
  assign d0.force_high = 1'b0;
  assign d0.src_level = div_src;

  assign d1.low_cnt = s_r.cnt1[`LOW_MSB:`LOW_LSB]; // see R8
  assign d1.high_cnt = s_r.cnt1[`HIGH_MSB:`HIGH_LSB]; // see R9
  assign d1.phase = s_r.ctl1[`PH_MSB:`PH_LSB];
  assign d1.start_high = s_r.ctl1[`BIT_START];
  assign d1.dcc_en = 1'b0;
  assign d1.bypass = s_r.ctl1[`BIT_BYPASS]; // see R10, R11
  assign d1.hold = sync_active & ~s_r.ctl1[`BIT_NOSYNC]; // see R12
  // forcing only acts with sync ignored
  assign d1.force_high = s_r.ctl1[`BIT_FORCE]
    & s_r.ctl1[`BIT_NOSYNC]; // see R13
  assign d1.src_level = div_src;

  div_core u_div0 (
    .aclk(aclk),
    .aresetn(aresetn),
    .cfg(d0.core)
  );

  div_core u_div1 (
    .aclk(aclk),
    .aresetn(aresetn),
    .cfg(d1.core)
  );

  // ****************************************************************
  // output routing
  // ****************************************************************
  pair_router u_pair0 (
    .aclk(aclk),
    .aresetn(aresetn),
    .direct(s_r.route0[`BIT_DIRECT]),
    .src_sel(s_r.srcsel),
    .osc_level(osc_clk_level),
    .ext_level(ext_clk_level),
    .div_level(d0.div_out),
    .out_a(pair0_output_a),
    .out_b(pair0_output_b)
  );

  assign pair1_output_a = s_r.p1a;
  assign pair1_output_b = s_r.p1b;

  // ****************************************************************
  // bus outputs
  // ****************************************************************
  assign awready = s_r.awready;
  assign wready = s_r.wready;
  assign bvalid = s_r.bvalid;
  assign bresp = s_r.bresp;
  assign arready = s_r.arready;
  assign rvalid = s_r.rvalid;
  assign rresp = s_r.rresp;
  assign rdata = s_r.rdata;

  // ****************************************************************
  // read decode
  // ****************************************************************
  always_comb begin
    rd_hit = 1'b1;
    rd_val = 32'h0000_0000;
    if (s_r.ar_idx == `IDX_CNT0) begin
      rd_val = {24'h00_0000, s_r.cnt0};
    end else if (s_r.ar_idx == `IDX_START0) begin
      rd_val = {24'h00_0000, s_r.start0};
    end else if (s_r.ar_idx == `IDX_ROUTE0) begin
      rd_val = {24'h00_0000, s_r.route0};
    end else if (s_r.ar_idx == `IDX_CNT1) begin
      rd_val = {24'h00_0000, s_r.cnt1};
    end else if (s_r.ar_idx == `IDX_CTL1) begin
      rd_val = {24'h00_0000, s_r.ctl1};
    end else if (s_r.ar_idx == `IDX_SRCSEL) begin
      rd_val = {30'h0000_0000, s_r.srcsel};
    end else if (s_r.ar_idx == `IDX_STATUS) begin
      // live levels: inverted sync pin, divider results, pair outputs
      rd_val = {26'h000_0000, sync_active, d1.div_out, d0.div_out,
        s_r.p1a, pair0_output_b, pair0_output_a};
    end else begin
      rd_hit = 1'b0;
    end
  end

  // ****************************************************************
  // bus handshakes and register writes
  // ****************************************************************
  always_comb begin
    s_nxt = s_r;
    wr_hit = 1'b1;
    s_nxt.p1a = d1.div_out;
    s_nxt.p1b = d1.div_out;

    if (awvalid && s_r.awready) begin
      s_nxt.aw_have = 1'b1;
      s_nxt.aw_idx = awaddr[11:2];
    end
    if (wvalid && s_r.wready) begin
      s_nxt.w_have = 1'b1;
      s_nxt.wbyte = wdata[7:0];
      s_nxt.wlane0 = wstrb[0];
    end

    if (s_r.aw_have && s_r.w_have && !s_r.bvalid) begin
      s_nxt.aw_have = 1'b0;
      s_nxt.w_have = 1'b0;
      s_nxt.bvalid = 1'b1;
      if (s_r.aw_idx == `IDX_CNT0) begin
        if (s_r.wlane0) s_nxt.cnt0 = s_r.wbyte;
      end else if (s_r.aw_idx == `IDX_START0) begin
        if (s_r.wlane0) s_nxt.start0 = s_r.wbyte;
      end else if (s_r.aw_idx == `IDX_ROUTE0) begin
        if (s_r.wlane0) s_nxt.route0 = s_r.wbyte;
      end else if (s_r.aw_idx == `IDX_CNT1) begin
        if (s_r.wlane0) s_nxt.cnt1 = s_r.wbyte;
      end else if (s_r.aw_idx == `IDX_CTL1) begin
        if (s_r.wlane0) s_nxt.ctl1 = s_r.wbyte;
      end else if (s_r.aw_idx == `IDX_SRCSEL) begin
        if (s_r.wlane0) s_nxt.srcsel = s_r.wbyte[1:0];
      end else begin
        wr_hit = 1'b0;
      end
      s_nxt.bresp = wr_hit ? `RESP_OKAY : `RESP_DECERR;
    end else if (s_r.bvalid && bready) begin
      s_nxt.bvalid = 1'b0;
    end
    // one write in flight: stall both channels until the answer is taken
    s_nxt.awready = ~s_nxt.aw_have & ~s_nxt.bvalid;
    s_nxt.wready = ~s_nxt.w_have & ~s_nxt.bvalid;

    if (arvalid && s_r.arready) begin
      s_nxt.ar_have = 1'b1;
      s_nxt.ar_idx = araddr[11:2];
    end
    if (s_r.ar_have) begin
      s_nxt.ar_have = 1'b0;
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata = rd_val;
      s_nxt.rresp = rd_hit ? `RESP_OKAY : `RESP_DECERR;
    end else if (s_r.rvalid && rready) begin
      s_nxt.rvalid = 1'b0;
    end
    s_nxt.arready = ~s_nxt.ar_have & ~s_nxt.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
      s_r.cnt0 <= `RST_REG8;
      s_r.start0 <= `RST_REG8;
      s_r.route0 <= `RST_REG8; // see R3, R7
      s_r.cnt1 <= `RST_REG8; // see R8, R9
      s_r.ctl1 <= `RST_REG8; // see R11
      s_r.srcsel <= `RST_SRCSEL;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule // output_channel_divider_config
`default_nettype wire

/* design/ocd_params.svh */
// register indices, field positions, reset values and codes of the divider
// configuration block; included by the package users, holds no logic
`ifndef OCD_PARAMS_SVH
`define OCD_PARAMS_SVH

// register indices; byte address is four times the index
`define IDX_CNT0 10'h190
`define IDX_START0 10'h191
`define IDX_ROUTE0 10'h192
`define IDX_CNT1 10'h193
`define IDX_CTL1 10'h194
`define IDX_SRCSEL 10'h1E1
`define IDX_STATUS 10'h1F0

// field positions
`define LOW_MSB 7
`define LOW_LSB 4
`define HIGH_MSB 3
`define HIGH_LSB 0
`define PH_MSB 3
`define PH_LSB 0
`define BIT_START 4
`define BIT_FORCE 5
`define BIT_NOSYNC 6
`define BIT_BYPASS 7
`define BIT_DIRECT 1
`define BIT_DCC_OFF 0

// reset values
`define RST_REG8 8'h00
`define RST_SRCSEL 2'h0

// source-select codes
`define SRC_EXT 2'h0
`define SRC_OSC 2'h2

// bus answers
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3

`endif

/* design/ocd_pkg.sv */
// types shared by the divider configuration block
// assumes ocd_params.svh is compiled alongside
package ocd_pkg;

  typedef enum logic [1:0] {
    DV_WAIT = 2'b00,
    DV_LOW = 2'b01,
    DV_HIGH = 2'b10
  } div_phase_t;

  typedef struct packed {
    div_phase_t ph;
    logic [4:0] cnt;
    logic src_q;
    logic run_lvl;
    logic out;
  } div_state_t;

  typedef struct packed {
    logic a;
    logic b;
  } pair_state_t;

  typedef struct packed {
    logic [7:0] cnt0;
    logic [7:0] start0;
    logic [7:0] route0;
    logic [7:0] cnt1;
    logic [7:0] ctl1;
    logic [1:0] srcsel;
    logic awready;
    logic wready;
    logic aw_have;
    logic w_have;
    logic [9:0] aw_idx;
    logic [7:0] wbyte;
    logic wlane0;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic ar_have;
    logic [9:0] ar_idx;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic p1a;
    logic p1b;
  } top_state_t;

endpackage

/* design/div_cfg_if.sv */
// settings and result of one integer divider
// driven by the register block, read by div_core
`timescale 1ns/100ps
`default_nettype none
interface div_cfg_if;
  logic [3:0] low_cnt;
  logic [3:0] high_cnt;
  logic [3:0] phase;
  logic start_high;
  logic dcc_en;
  logic bypass;
  logic hold;
  logic force_high;
  logic src_level;
  logic div_out;
  modport ctrl (
    output low_cnt, high_cnt, phase, start_high, dcc_en, bypass, hold,
    output force_high, src_level,
    input div_out
  );
  modport core (
    input low_cnt, high_cnt, phase, start_high, dcc_en, bypass, hold,
    input force_high, src_level,
    output div_out
  );
endinterface // div_cfg_if
`default_nettype wire

/* design/div_core.sv */
// one integer divider counting rising edges of a sampled source level
// assumes the source level is synchronous to aclk and slower than aclk/2
`timescale 1ns/100ps
`default_nettype none
module div_core (
  input wire logic aclk,
  input wire logic aresetn,
  div_cfg_if.core cfg
);
  ocd_pkg::div_state_t s_r;
  ocd_pkg::div_state_t s_nxt;
  logic [5:0] total;
  logic [4:0] hlen;
  logic [4:0] llen;
  logic rise;

  assign cfg.div_out = s_r.out;

  always_comb begin
    total = 6'(cfg.low_cnt) + 6'(cfg.high_cnt) + 6'h02; // see R15
    if (cfg.dcc_en) begin
      hlen = 5'(total >> 1); // see R7
    end else begin
      hlen = 5'(cfg.high_cnt) + 5'h01; // see R9
    end
    llen = 5'(total - 6'(hlen)); // see R8
    rise = cfg.src_level & ~s_r.src_q;
    s_nxt = s_r;
    s_nxt.src_q = cfg.src_level;
    if (cfg.hold || cfg.bypass) begin
      // restart point: phase delay then start level
      s_nxt.ph = ocd_pkg::DV_WAIT; // see R12
      s_nxt.cnt = 5'(cfg.phase);
      s_nxt.run_lvl = cfg.start_high;
    end else if (rise) begin
      case (s_r.ph)
        ocd_pkg::DV_WAIT: begin
          if (s_r.cnt == 5'h00) begin
            s_nxt.ph = cfg.start_high ? ocd_pkg::DV_HIGH : ocd_pkg::DV_LOW;
            s_nxt.cnt = cfg.start_high ? hlen - 5'h01 : llen - 5'h01;
            s_nxt.run_lvl = cfg.start_high; // see R1, R14
          end else begin
            s_nxt.cnt = s_r.cnt - 5'h01; // see R2
          end
        end
        ocd_pkg::DV_LOW: begin
          if (s_r.cnt == 5'h00) begin
            s_nxt.ph = ocd_pkg::DV_HIGH;
            s_nxt.cnt = hlen - 5'h01;
            s_nxt.run_lvl = 1'b1;
          end else begin
            s_nxt.cnt = s_r.cnt - 5'h01;
          end
        end
        ocd_pkg::DV_HIGH: begin
          if (s_r.cnt == 5'h00) begin
            s_nxt.ph = ocd_pkg::DV_LOW;
            s_nxt.cnt = llen - 5'h01;
            s_nxt.run_lvl = 1'b0;
          end else begin
            s_nxt.cnt = s_r.cnt - 5'h01;
          end
        end
        default: begin
          s_nxt.ph = ocd_pkg::DV_WAIT;
        end
      endcase
    end else if (s_r.ph == ocd_pkg::DV_WAIT) begin
      s_nxt.run_lvl = cfg.start_high; // see R1
    end
    if (cfg.force_high) begin
      s_nxt.out = 1'b1; // see R13
    end else if (cfg.bypass) begin
      s_nxt.out = cfg.src_level; // see R10
    end else begin
      s_nxt.out = s_nxt.run_lvl;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule // div_core
`default_nettype wire

/* design/pair_router.sv */
// drives both outputs of a pair from the divider or straight from a source
// assumes all levels are synchronous to aclk
`timescale 1ns/100ps
`default_nettype none
`include "ocd_params.svh"
module pair_router (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic direct,
  input wire logic [1:0] src_sel,
  input wire logic osc_level,
  input wire logic ext_level,
  input wire logic div_level,
  output logic out_a,
  output logic out_b
);
  ocd_pkg::pair_state_t s_r;
  ocd_pkg::pair_state_t s_nxt;
  logic lvl;

  assign out_a = s_r.a;
  assign out_b = s_r.b;

  always_comb begin
    if (direct && src_sel == `SRC_OSC) begin
      lvl = osc_level; // see R4
    end else if (direct && src_sel == `SRC_EXT) begin
      lvl = ext_level; // see R5
    end else begin
      lvl = div_level; // see R3, R6
    end
    s_nxt.a = lvl;
    s_nxt.b = lvl;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule // pair_router
`default_nettype wire

/* verification/output_channel_divider_config_props.sv */
// concurrent checks on the top ports of the divider configuration block
// assumes binding onto output_channel_divider_config, one clock aclk
`timescale 1ns/100ps
`default_nettype none
module output_channel_divider_config_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic pair0_output_a,
  input wire logic pair0_output_b,
  input wire logic pair1_output_a,
  input wire logic pair1_output_b
);
  default clocking cb @(posedge aclk); endclocking
  // ****************
  // output relations
  // ****************
  chk_pair0_same: assert property (disable iff (!aresetn)
    pair0_output_a == pair0_output_b) else $error("pair 0 split");
  chk_pair1_same: assert property (disable iff (!aresetn)
    pair1_output_a == pair1_output_b) else $error("pair 1 split");
  chk_reset_low: assert property (!aresetn |=>
    !pair0_output_a && !pair1_output_a && !bvalid && !rvalid)
    else $error("outputs not low after reset");
  // ****************
  // register bus
  // ****************
  chk_bvalid_hold: assert property (disable iff (!aresetn)
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped");
  chk_rvalid_hold: assert property (disable iff (!aresetn)
    rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read answer dropped");
  chk_read_answer: assert property (disable iff (!aresetn)
    arvalid && arready |-> ##[1:2] rvalid) else $error("read late");
  chk_resp_code: assert property (disable iff (!aresetn)
    rvalid |-> rresp == 2'h0 || rresp == 2'h3) else $error("bad rresp");
  chk_busy_refuse: assert property (disable iff (!aresetn)
    bvalid |-> !awready && !wready) else $error("ready while busy");
  chk_write_answer: assert property (disable iff (!aresetn)
    awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
    else $error("write late");
endmodule // output_channel_divider_config_props
`default_nettype wire

/* verification/output_channel_divider_config_tb_top.sv */
// register-level test of the divider configuration block
// assumes the design files and ocd_params.svh are compiled first
`timescale 1ns/100ps
`default_nettype none
`include "ocd_params.svh"
module output_channel_divider_config_tb_top;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic osc_clk_level = 1'b0;
  logic ext_clk_level = 1'b0;
  logic sync_n;
  logic p0a, p0b, p1a, p1b;
  logic [3:0] ph = 4'h0;
  int err_total, checks_done;
  output_channel_divider_config output_channel_divider_config_inst (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .osc_clk_level(osc_clk_level), .ext_clk_level(ext_clk_level),
    .sync_n(sync_n), .pair0_output_a(p0a), .pair0_output_b(p0b),
    .pair1_output_a(p1a), .pair1_output_b(p1b));
  // ****************
  // clock and sources
  // ****************
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  // oscillator period 4 aclk, external clock period 6 aclk
  always @(posedge aclk) begin
    ph <= (ph == 4'hB) ? 4'h0 : ph + 4'h1;
    osc_clk_level <= ph[1];
    ext_clk_level <= (ph >= 4'h3 && ph < 4'h6) || ph >= 4'h9;
  end
  // ****************
  // helpers
  // ****************
  task automatic results;
    if (err_total == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] v, e);
    checks_done++;
    if (v !== e) begin
      err_total++;
      $display("[ERR] %s exp %h seen %h", s, e, v);
    end
  endtask
  task automatic wr(input logic [9:0] i, input logic [7:0] d,
                    input logic [1:0] er);
    int n;
    logic [1:0] r;
    @(posedge aclk);
    awaddr <= {i, 2'h0};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      r = bresp;
      if (bvalid === 1'b1) break;
    end
    bready <= 1'b0;
    if (n == 50) begin
      err_total++;
      results();
    end
    chk("bresp", r, er);
  endtask
  task automatic rd(input logic [9:0] i, input logic [7:0] ed,
                    input logic [1:0] er);
    int n;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge aclk);
    araddr <= {i, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      d = rdata;
      r = rresp;
      if (rvalid === 1'b1) break;
    end
    rready <= 1'b0;
    if (n == 50) begin
      err_total++;
      results();
    end
    chk("rdata", d, {24'h0, ed});
    chk("rresp", r, er);
  endtask
  function automatic logic lv(input bit p);
    return p ? p1a : p0a;
  endfunction
  task automatic edge_wait(input bit p, input logic v);
    int n;
    for (n = 0; n < 300; n++) begin
      @(posedge aclk);
      #1;
      if (lv(p) === v) break;
    end
    if (n == 300) begin
      err_total++;
      results();
    end
  endtask
  // wait for two rising edges, then time one high and one low phase
  task automatic meas(input bit p, input int eh, el);
    int h, l;
    h = 0;
    l = 0;
    edge_wait(p, 1'b0);
    edge_wait(p, 1'b1);
    edge_wait(p, 1'b0);
    edge_wait(p, 1'b1);
    while (lv(p) === 1'b1 && h < 300) begin
      h++;
      @(posedge aclk);
      #1;
    end
    while (lv(p) === 1'b0 && l < 300) begin
      l++;
      @(posedge aclk);
      #1;
    end
    chk("high cycles", h, eh);
    chk("low cycles", l, el);
  endtask
  task automatic hold(input bit p, input logic v);
    int n;
    n = 0;
    repeat (8) @(posedge aclk);
    repeat (40) begin
      @(posedge aclk);
      #1;
      if (lv(p) === v) n++;
    end
    chk("held level", n, 40);
  endtask
  // ****************
  // main sequence
  // ****************
  initial begin
    logic [9:0] idx [6];
    idx = '{`IDX_CNT0, `IDX_START0, `IDX_ROUTE0, `IDX_CNT1, `IDX_CTL1,
           `IDX_SRCSEL};
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata} = {12'h000, 12'h000, 32'h0};
    wstrb = 4'hF;
    sync_n = 1'b1;
    err_total = 0;
    checks_done = 0;
    aresetn = 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (idx[k]) rd(idx[k], 8'h00, `RESP_OKAY);
    rd(10'h3FF, 8'h00, `RESP_DECERR);
    wr(`IDX_STATUS, 8'h01, `RESP_DECERR);
    wr(`IDX_CNT1, 8'hA5, `RESP_OKAY);
    rd(`IDX_CNT1, 8'hA5, `RESP_OKAY);
    wr(`IDX_CNT1, 8'h21, `RESP_OKAY);
    meas(1'b1, 12, 18);
    wr(`IDX_CTL1, 8'h80, `RESP_OKAY);
    meas(1'b1, 3, 3);
    wr(`IDX_CTL1, 8'h20, `RESP_OKAY);
    meas(1'b1, 12, 18);
    wr(`IDX_CTL1, 8'h60, `RESP_OKAY);
    hold(1'b1, 1'b1);
    wr(`IDX_CTL1, 8'h00, `RESP_OKAY);
    @(posedge aclk);
    sync_n <= 1'b0;
    hold(1'b1, 1'b0);
    rd(`IDX_STATUS, 8'h20, `RESP_OKAY);
    wr(`IDX_CTL1, 8'h40, `RESP_OKAY);
    meas(1'b1, 12, 18);
    wr(`IDX_START0, 8'h1F, `RESP_OKAY);
    rd(`IDX_START0, 8'h1F, `RESP_OKAY);
    hold(1'b0, 1'b1);
    wr(`IDX_START0, 8'h00, `RESP_OKAY);
    hold(1'b0, 1'b0);
    @(posedge aclk);
    sync_n <= 1'b1;
    wr(`IDX_CNT0, 8'h20, `RESP_OKAY);
    meas(1'b0, 12, 12);
    wr(`IDX_ROUTE0, 8'h01, `RESP_OKAY);
    meas(1'b0, 6, 18);
    wr(`IDX_SRCSEL, 8'h01, `RESP_OKAY);
    wr(`IDX_ROUTE0, 8'h03, `RESP_OKAY);
    meas(1'b0, 6, 18);
    wr(`IDX_SRCSEL, {6'h00, `SRC_EXT}, `RESP_OKAY);
    meas(1'b0, 3, 3);
    wr(`IDX_SRCSEL, {6'h00, `SRC_OSC}, `RESP_OKAY);
    meas(1'b0, 2, 2);
    wr(`IDX_ROUTE0, 8'h00, `RESP_OKAY);
    meas(1'b0, 8, 8);
    results();
  end
endmodule // output_channel_divider_config_tb_top
bind output_channel_divider_config output_channel_divider_config_props
  props_inst (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
  .awready(awready), .wvalid(wvalid),
  .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
  .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
  .rvalid(rvalid), .rready(rready), .pair0_output_a(pair0_output_a),
  .pair0_output_b(pair0_output_b), .pair1_output_a(pair1_output_a),
  .pair1_output_b(pair1_output_b));
`default_nettype wire
